// [ids_mem_if.sv]
// Memory word port shared by the sequencer and its memory port
`timescale 1ns/100ps
`default_nettype none
interface ids_mem_if;
  logic req;
  logic we;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic done;
  logic [15:0] rdata;
  modport seq (output req, output we, output addr, output wdata, input done, input rdata);
  modport port (input req, input we, input addr, input wdata, output done, output rdata);
endinterface : ids_mem_if
`default_nettype wire

// [ids_mem_port.sv]
// Registers one memory request onto the outside bus
`timescale 1ns/100ps
`default_nettype none
module ids_mem_port (
  input wire logic clock,
  input wire logic rst_n,
  ids_mem_if.port mif,
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata
);
  typedef struct packed {
    logic req;
    logic we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ids_port_st_t;
  ids_port_st_t s_r;
  ids_port_st_t s_nxt;
  always_comb begin
    s_nxt = s_r;
    if (!s_r.req && mif.req) begin
      s_nxt.req = 1'b1;
      s_nxt.we = mif.we;
      s_nxt.addr = mif.addr;
      s_nxt.wdata = mif.wdata;
    end else if (s_r.req && mem_ack) begin
      s_nxt.req = 1'b0;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
  assign mem_req = s_r.req;
  assign mem_we = s_r.we;
  assign mem_addr = s_r.addr;
  assign mem_wdata = s_r.wdata;
  assign mif.done = s_r.req && mem_ack;
  assign mif.rdata = mem_rdata;
endmodule : ids_mem_port
`default_nettype wire

// [ids_params.svh]
// Constants for the interrupt dispatch sequencer
`ifndef IDS_PARAMS_SVH
`define IDS_PARAMS_SVH
`define IDS_STATUS_INT 16'h8001
`define IDS_SEG_RECEIVER 8'h01
`define IDS_MARKER_WORDS 3'h4
`define IDS_STACK_REGS 3'h4
`define IDS_LOCK_OFS 16'h0012
`define IDS_MARKER_DEV_OFS 16'h0003
`define IDS_PRIV_BIT 15
`define IDS_SEG_LSB 0
`endif

// [ids_pkg.sv]
// Types for the interrupt dispatch sequencer
package ids_pkg;
  typedef enum logic [4:0] {
    IDS_IDLE, IDS_FLUSH, IDS_MARK, IDS_PARM, IDS_SEG_RD, IDS_SEG_WAIT, IDS_XFER_RD, IDS_XFER_WAIT,
    IDS_LOCK_RD, IDS_LOCK_WAIT, IDS_LOCK_WR, IDS_BASE_RD, IDS_BASE_WAIT, IDS_BASE_WR, IDS_DEV_RD, IDS_DEV_WAIT,
    IDS_EXIT_DEC, IDS_HALT
  } ids_state_t;
  typedef enum logic [1:0] {
    IDS_OP_NONE, IDS_OP_DISPATCH, IDS_OP_LOCK, IDS_OP_UNLOCK
  } ids_op_t;
endpackage : ids_pkg

// [ids_seq_properties.sv]
// Port-level checker for the interrupt dispatch sequencer
`timescale 1ns/100ps
`default_nettype none
`include "ids_params.svh"
module ids_seq_properties (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic instr_boundary,
  input wire logic [15:0] pending_interrupt_reg_a,
  input wire logic [15:0] pending_interrupt_reg_b,
  input wire logic [15:0] status_in,
  input wire logic in_handler,
  input wire logic dispatch_instr,
  input wire logic dispatcher_lock_instr,
  input wire logic dispatcher_unlock_instr,
  input wire logic interrupt_exit_instr,
  input wire logic busy,
  input wire logic done,
  input wire logic halted,
  input wire logic [15:0] status_reg,
  input wire logic [15:0] ext_label,
  input wire logic fetch_start,
  input wire logic cond_code_greater,
  input wire logic enter_dispatcher,
  input wire logic reset_int_valid,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic mem_ack
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_pend_start;
    instr_boundary && !busy && !halted && (|{pending_interrupt_reg_a, pending_interrupt_reg_b}) |=> busy;
  endproperty
  a_pend_start: assert property (p_pend_start) else $error("pending interrupt not taken");
  property p_bound_only;
    $rose(busy) |-> $past(instr_boundary | dispatch_instr | dispatcher_lock_instr | dispatcher_unlock_instr
      | interrupt_exit_instr);
  endproperty
  a_bound_only: assert property (p_bound_only) else $error("sequence started off a boundary");
  property p_fetch_done;
    fetch_start |-> done && status_reg == `IDS_STATUS_INT;
  endproperty
  a_fetch_done: assert property (p_fetch_done) else $error("entry status wrong");
  property p_fetch_seg;
    fetch_start |-> ext_label[7:0] == `IDS_SEG_RECEIVER;
  endproperty
  a_fetch_seg: assert property (p_fetch_seg) else $error("label not aimed at segment one");
  property p_req_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("memory request dropped before ack");
  property p_halt_sticky;
    halted |=> halted;
  endproperty
  a_halt_sticky: assert property (p_halt_sticky) else $error("halt released without reset");
  property p_priv;
    enter_dispatcher && done |-> $past(status_in[15]) && !$past(in_handler);
  endproperty
  a_priv: assert property (p_priv) else $error("dispatcher entered when not allowed");
  property p_cc;
    $rose(cond_code_greater) |-> $past(in_handler);
  endproperty
  a_cc: assert property (p_cc) else $error("greater code set outside a handler");
  property p_rst_int;
    reset_int_valid |-> status_in[7:0] != `IDS_SEG_RECEIVER;
  endproperty
  a_rst_int: assert property (p_rst_int) else $error("reset interrupt from segment one");
  c_entry: cover property (fetch_start);
  c_dispatch_instr: cover property (enter_dispatcher);
  c_rst: cover property (reset_int_valid);
  c_halt: cover property ($rose(halted));
endmodule : ids_seq_properties
bind ids_sequencer ids_seq_properties u_props (.clock, .rst_n, .instr_boundary, .pending_interrupt_reg_a,
  .pending_interrupt_reg_b, .status_in, .in_handler, .dispatch_instr, .dispatcher_lock_instr,
  .dispatcher_unlock_instr, .interrupt_exit_instr, .busy, .done, .halted, .status_reg, .ext_label,
  .fetch_start, .cond_code_greater, .enter_dispatcher, .reset_int_valid, .mem_req, .mem_we, .mem_addr, .mem_ack);
`default_nettype wire

// [ids_sequencer.sv]
// Interrupt entry, dispatcher lock and interrupt exit sequencer
// Behaviour
// - Non-control-stack internal interrupts keep working on the user's stack.
// - Entry first writes all held top-of-stack registers to memory.
// - Then push four-word marker, then the interrupt parameter.
// - Entry copies the current instruction into the index register.
// - Entry builds an external label aimed at receiver code in segment 1.
// - Load code bank, base and limit from segment 1 table entry.
// - Status becomes privileged, segment 1, all else clear.
// - Program counter loaded from transfer-table local label, then fetch resumes.
// - Pending bits in the two pending registers start interrupt entry.
// - Dispatch runs the dispatcher only from privileged mode.
// - Dispatch inside a handler sets greater code and base bit 0.
// - Lock increments, unlock decrements the count; non-zero means locked.
// - Dispatch while locked sets base bit 0 and continues.
// - Pending-dispatch bit clears on unlock reaching zero, or on exit with count zero when marker bit 0 and base bit 0 are both set.
// - Unlock with count already zero halts the system.
// - Exit outside segment 1 sends reset-interrupt to device at marker+3.
// - Marker bit 0 clear: return to process if marker equals base, else lower interrupt.
// - Marker bit 0 set, base bit 0 clear: return to dispatcher.
// - Both set, count zero: clear base word, jump to dispatcher.
// - Both set, count non-zero: return, leave pending-dispatch bit set.
`timescale 1ns/100ps
`default_nettype none
`include "ids_params.svh"
module ids_sequencer (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic instr_boundary,
  input wire logic [15:0] pending_interrupt_reg_a,
  input wire logic [15:0] pending_interrupt_reg_b,
  input wire logic [7:0] int_xfer_index,
  input wire logic [15:0] int_parameter,
  input wire logic [15:0] current_instr,
  input wire logic [2:0] stack_reg_count,
  input wire logic [15:0] stack_reg_word0,
  input wire logic [15:0] stack_reg_word1,
  input wire logic [15:0] stack_reg_word2,
  input wire logic [15:0] stack_reg_word3,
  input wire logic [15:0] stack_ptr,
  input wire logic [15:0] marker_word0,
  input wire logic [15:0] marker_word1,
  input wire logic [15:0] marker_word2,
  input wire logic [15:0] marker_word3,
  input wire logic [15:0] status_in,
  input wire logic [15:0] marker_ptr,
  input wire logic [15:0] interrupt_stack_base,
  input wire logic [15:0] code_segment_table,
  input wire logic [15:0] segment_transfer_table,
  input wire logic in_handler,
  input wire logic dispatch_instr,
  input wire logic dispatcher_lock_instr,
  input wire logic dispatcher_unlock_instr,
  input wire logic interrupt_exit_instr,
  output logic busy,
  output logic done,
  output logic halted,
  output logic [15:0] index_reg,
  output logic [15:0] status_reg,
  output logic [15:0] code_bank,
  output logic [15:0] code_base,
  output logic [15:0] code_limit,
  output logic [15:0] prog_counter,
  output logic [15:0] ext_label,
  output logic fetch_start,
  output logic cond_code_greater,
  output logic enter_dispatcher,
  output logic [2:0] exit_path,
  output logic reset_int_valid,
  output logic [15:0] reset_int_device,
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata
);
  typedef struct packed {
    ids_pkg::ids_state_t st;
    ids_pkg::ids_op_t op;
    logic [2:0] cnt;
    logic [15:0] sp;
    logic [15:0] lock_cnt;
    logic [15:0] base_word;
    logic busy;
    logic done;
    logic halted;
    logic [15:0] index_reg;
    logic [15:0] status_reg;
    logic [15:0] code_bank;
    logic [15:0] code_base;
    logic [15:0] code_limit;
    logic [15:0] prog_counter;
    logic [15:0] ext_label;
    logic fetch_start;
    logic cc_greater;
    logic enter_dispatch_instr;
    logic [2:0] exit_path;
    logic rst_valid;
    logic [15:0] rst_dev;
    logic mreq;
    logic mwe;
    logic [15:0] maddr;
    logic [15:0] mwdata;
  } ids_seq_st_t;
  ids_seq_st_t s_r;
  ids_seq_st_t s_nxt;
  ids_mem_if mif ();
  logic [15:0] stack_word [0:3];
  logic [15:0] mark_word [0:3];
  logic pending_any;
  logic [15:0] lock_addr;
  assign stack_word[0] = stack_reg_word0;
  assign stack_word[1] = stack_reg_word1;
  assign stack_word[2] = stack_reg_word2;
  assign stack_word[3] = stack_reg_word3;
  assign mark_word[0] = marker_word0;
  assign mark_word[1] = marker_word1;
  assign mark_word[2] = marker_word2;
  assign mark_word[3] = marker_word3;
  assign pending_any = (|pending_interrupt_reg_a) || (|pending_interrupt_reg_b);
  assign lock_addr = interrupt_stack_base - `IDS_LOCK_OFS;
  assign mif.req = s_r.mreq;
  assign mif.we = s_r.mwe;
  assign mif.addr = s_r.maddr;
  assign mif.wdata = s_r.mwdata;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.fetch_start = 1'b0;
    s_nxt.rst_valid = 1'b0;
    s_nxt.mreq = 1'b0;
    s_nxt.enter_dispatch_instr = 1'b0;
    case (s_r.st)
      ids_pkg::IDS_IDLE: begin
        s_nxt.busy = 1'b0;
        if (instr_boundary && pending_any) begin
          s_nxt.busy = 1'b1;
          s_nxt.sp = stack_ptr;
          s_nxt.cnt = 3'h0;
          s_nxt.index_reg = current_instr;
          s_nxt.ext_label = {int_xfer_index, `IDS_SEG_RECEIVER};
          s_nxt.st = ids_pkg::IDS_FLUSH;
        end else if (dispatch_instr) begin
          s_nxt.busy = 1'b1;
          s_nxt.op = ids_pkg::IDS_OP_DISPATCH;
          s_nxt.st = ids_pkg::IDS_LOCK_RD;
        end else if (dispatcher_lock_instr) begin
          s_nxt.busy = 1'b1;
          s_nxt.op = ids_pkg::IDS_OP_LOCK;
          s_nxt.st = ids_pkg::IDS_LOCK_RD;
        end else if (dispatcher_unlock_instr) begin
          s_nxt.busy = 1'b1;
          s_nxt.op = ids_pkg::IDS_OP_UNLOCK;
          s_nxt.st = ids_pkg::IDS_LOCK_RD;
        end else if (interrupt_exit_instr) begin
          s_nxt.busy = 1'b1;
          s_nxt.op = ids_pkg::IDS_OP_NONE;
          s_nxt.st = ids_pkg::IDS_LOCK_RD;
        end
      end
      ids_pkg::IDS_FLUSH: begin
        if (s_r.cnt >= stack_reg_count || s_r.cnt >= `IDS_STACK_REGS) begin
          s_nxt.cnt = 3'h0;
          s_nxt.st = ids_pkg::IDS_MARK;
        end else if (!s_r.mreq && !mem_req) begin
          // No new request while the port still holds one, so its ack is never lost
          s_nxt.mreq = 1'b1;
          s_nxt.mwe = 1'b1;
          s_nxt.maddr = s_r.sp + 16'h0001;
          s_nxt.mwdata = stack_word[s_r.cnt[1:0]];
        end else if (mif.done) begin
          s_nxt.sp = s_r.sp + 16'h0001;
          s_nxt.cnt = s_r.cnt + 3'h1;
        end
      end
      ids_pkg::IDS_MARK: begin
        if (s_r.cnt >= `IDS_MARKER_WORDS) begin
          s_nxt.st = ids_pkg::IDS_PARM;
        end else if (!s_r.mreq && !mem_req) begin
          s_nxt.mreq = 1'b1;
          s_nxt.mwe = 1'b1;
          s_nxt.maddr = s_r.sp + 16'h0001;
          s_nxt.mwdata = mark_word[s_r.cnt[1:0]];
        end else if (mif.done) begin
          s_nxt.sp = s_r.sp + 16'h0001;
          s_nxt.cnt = s_r.cnt + 3'h1;
        end
      end
      ids_pkg::IDS_PARM: begin
        if (!s_r.mreq && !mem_req) begin
          s_nxt.mreq = 1'b1;
          s_nxt.mwe = 1'b1;
          s_nxt.maddr = s_r.sp + 16'h0001;
          s_nxt.mwdata = int_parameter;
        end else if (mif.done) begin
          s_nxt.sp = s_r.sp + 16'h0001;
          s_nxt.cnt = 3'h0;
          s_nxt.st = ids_pkg::IDS_SEG_RD;
        end
      end
      ids_pkg::IDS_SEG_RD: begin
        if (mif.done) begin
          s_nxt.cnt = s_r.cnt + 3'h1;
          if (s_r.cnt == 3'h0) begin
            s_nxt.code_bank = mif.rdata;
          end else if (s_r.cnt == 3'h1) begin
            s_nxt.code_base = mif.rdata;
          end else begin
            s_nxt.code_limit = mif.rdata;
            s_nxt.status_reg = `IDS_STATUS_INT;
            s_nxt.st = ids_pkg::IDS_XFER_RD;
          end
        end else if (!s_r.mreq && !mem_req) begin
          s_nxt.mreq = 1'b1;
          s_nxt.mwe = 1'b0;
          s_nxt.maddr = code_segment_table + {13'h0000, s_r.cnt};
        end
      end
      ids_pkg::IDS_XFER_RD: begin
        if (!s_r.mreq && !mif.req) begin
          s_nxt.mreq = 1'b1;
          s_nxt.mwe = 1'b0;
          s_nxt.maddr = segment_transfer_table + {8'h00, s_r.ext_label[15:8]};
          s_nxt.st = ids_pkg::IDS_XFER_WAIT;
        end
      end
      ids_pkg::IDS_XFER_WAIT: begin
        if (mif.done) begin
          s_nxt.prog_counter = s_r.code_base + mif.rdata;
          s_nxt.fetch_start = 1'b1;
          s_nxt.done = 1'b1;
          s_nxt.st = ids_pkg::IDS_IDLE;
        end
      end
      ids_pkg::IDS_LOCK_RD: begin
        if (!s_r.mreq && !mif.req) begin
          s_nxt.mreq = 1'b1;
          s_nxt.mwe = 1'b0;
          s_nxt.maddr = lock_addr;
          s_nxt.st = ids_pkg::IDS_LOCK_WAIT;
        end
      end
      ids_pkg::IDS_LOCK_WAIT: begin
        if (mif.done) begin
          s_nxt.lock_cnt = mif.rdata;
          s_nxt.st = ids_pkg::IDS_BASE_RD;
        end
      end
      ids_pkg::IDS_BASE_RD: begin
        if (!s_r.mreq && !mif.req) begin
          s_nxt.mreq = 1'b1;
          s_nxt.mwe = 1'b0;
          s_nxt.maddr = interrupt_stack_base;
          s_nxt.st = ids_pkg::IDS_BASE_WAIT;
        end
      end
      ids_pkg::IDS_BASE_WAIT: begin
        if (mif.done) begin
          s_nxt.base_word = mif.rdata;
          s_nxt.st = ids_pkg::IDS_LOCK_WR;
          case (s_r.op)
            ids_pkg::IDS_OP_DISPATCH: begin
              if (!status_in[`IDS_PRIV_BIT]) begin
                s_nxt.done = 1'b1;
                s_nxt.st = ids_pkg::IDS_IDLE;
              end else if (in_handler || s_r.lock_cnt != 16'h0000) begin
                s_nxt.cc_greater = in_handler;
                s_nxt.base_word = mif.rdata | 16'h0001;
                s_nxt.st = ids_pkg::IDS_BASE_WR;
              end else begin
                s_nxt.enter_dispatch_instr = 1'b1;
                s_nxt.done = 1'b1;
                s_nxt.st = ids_pkg::IDS_IDLE;
              end
            end
            ids_pkg::IDS_OP_LOCK: begin
              s_nxt.lock_cnt = s_r.lock_cnt + 16'h0001;
            end
            ids_pkg::IDS_OP_UNLOCK: begin
              if (s_r.lock_cnt == 16'h0000) begin
                s_nxt.st = ids_pkg::IDS_HALT;
              end else begin
                s_nxt.lock_cnt = s_r.lock_cnt - 16'h0001;
                if (s_r.lock_cnt == 16'h0001) begin
                  s_nxt.base_word = mif.rdata & 16'hfffe;
                end
              end
            end
            default: begin
              s_nxt.st = (status_in[7:0] != `IDS_SEG_RECEIVER) ? ids_pkg::IDS_DEV_RD : ids_pkg::IDS_EXIT_DEC;
            end
          endcase
        end
      end
      ids_pkg::IDS_LOCK_WR: begin
        if (!s_r.mreq && !mem_req) begin
          s_nxt.mreq = 1'b1;
          s_nxt.mwe = 1'b1;
          s_nxt.maddr = lock_addr;
          s_nxt.mwdata = s_r.lock_cnt;
        end else if (mif.done) begin
          s_nxt.st = ids_pkg::IDS_BASE_WR;
        end
      end
      ids_pkg::IDS_BASE_WR: begin
        if (!s_r.mreq && !mem_req) begin
          s_nxt.mreq = 1'b1;
          s_nxt.mwe = 1'b1;
          s_nxt.maddr = interrupt_stack_base;
          s_nxt.mwdata = s_r.base_word;
        end else if (mif.done) begin
          s_nxt.done = 1'b1;
          s_nxt.st = ids_pkg::IDS_IDLE;
        end
      end
      ids_pkg::IDS_DEV_RD: begin
        if (!s_r.mreq && !mif.req) begin
          s_nxt.mreq = 1'b1;
          s_nxt.mwe = 1'b0;
          s_nxt.maddr = marker_ptr + `IDS_MARKER_DEV_OFS;
          s_nxt.st = ids_pkg::IDS_DEV_WAIT;
        end
      end
      ids_pkg::IDS_DEV_WAIT: begin
        if (mif.done) begin
          s_nxt.rst_valid = 1'b1;
          s_nxt.rst_dev = mif.rdata;
          s_nxt.st = ids_pkg::IDS_EXIT_DEC;
        end
      end
      ids_pkg::IDS_EXIT_DEC: begin
        s_nxt.done = 1'b1;
        s_nxt.st = ids_pkg::IDS_IDLE;
        if (!marker_ptr[0]) begin
          s_nxt.exit_path = (marker_ptr == interrupt_stack_base) ? 3'h2 : 3'h3;
        end else if (!s_r.base_word[0]) begin
          s_nxt.exit_path = 3'h4;
        end else if (s_r.lock_cnt == 16'h0000) begin
          s_nxt.exit_path = 3'h5;
          s_nxt.enter_dispatch_instr = 1'b1;
          s_nxt.base_word = 16'h0000;
          s_nxt.done = 1'b0;
          s_nxt.st = ids_pkg::IDS_BASE_WR;
        end else begin
          s_nxt.exit_path = (marker_ptr == interrupt_stack_base) ? 3'h6 : 3'h7;
        end
      end
      ids_pkg::IDS_HALT: begin
        s_nxt.halted = 1'b1;
      end
      default: begin
        s_nxt.st = ids_pkg::IDS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  ids_mem_port u_port (
    .clock(clock),
    .rst_n(rst_n),
    .mif(mif.port),
    .mem_req(mem_req),
    .mem_we(mem_we),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_ack(mem_ack),
    .mem_rdata(mem_rdata)
  );

  assign busy = s_r.busy;
  assign done = s_r.done;
  assign halted = s_r.halted;
  assign index_reg = s_r.index_reg;
  assign status_reg = s_r.status_reg;
  assign code_bank = s_r.code_bank;
  assign code_base = s_r.code_base;
  assign code_limit = s_r.code_limit;
  assign prog_counter = s_r.prog_counter;
  assign ext_label = s_r.ext_label;
  assign fetch_start = s_r.fetch_start;
  assign cond_code_greater = s_r.cc_greater;
  assign enter_dispatcher = s_r.enter_dispatch_instr;
  assign exit_path = s_r.exit_path;
  assign reset_int_valid = s_r.rst_valid;
  assign reset_int_device = s_r.rst_dev;
endmodule : ids_sequencer
`default_nettype wire

// [ids_tb.sv]
// Self-checking bench for the interrupt dispatch sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clock = 1'b0, rst_n = 1'b0, instr_boundary = 1'b0, in_handler = 1'b0, mem_ack = 1'b0;
  logic dispatch_instr = 1'b0, dispatcher_lock_instr = 1'b0;
  logic dispatcher_unlock_instr = 1'b0, interrupt_exit_instr = 1'b0;
  logic [7:0] int_xfer_index = 8'h03;
  logic [2:0] stack_reg_count = 3'h4;
  logic [15:0] pending_interrupt_reg_a = 16'h0000, pending_interrupt_reg_b = 16'h0000;
  logic [15:0] int_parameter = 16'h55aa, current_instr = 16'h1234, stack_ptr = 16'h0010;
  logic [15:0] stack_reg_word0 = 16'ha000, stack_reg_word1 = 16'ha001;
  logic [15:0] stack_reg_word2 = 16'ha002, stack_reg_word3 = 16'ha003;
  logic [15:0] marker_word0 = 16'hb000, marker_word1 = 16'hb001, marker_word2 = 16'hb002, marker_word3 = 16'hb003;
  logic [15:0] status_in = 16'h0005, marker_ptr = 16'h0080, interrupt_stack_base = 16'h0080;
  logic [15:0] code_segment_table = 16'h0040, segment_transfer_table = 16'h0060, mem_rdata = 16'h0000;
  logic busy, done, halted, fetch_start, cond_code_greater, enter_dispatcher, reset_int_valid, mem_req, mem_we;
  logic [15:0] index_reg, status_reg, code_bank, code_base, code_limit, prog_counter, ext_label;
  logic [15:0] reset_int_device, mem_addr, mem_wdata;
  logic [2:0] exit_path;
  logic [15:0] mem [0:255];
  logic [31:0] wlog [$];
  logic [2:0] ev = 3'b000;
  // Exit cases: marker byte, base byte, lock count, segment, expected path
  logic [27:0] xt [8] = '{28'h8080012, 28'h9080013, 28'h9180014, 28'h8181015,
    28'h9181015, 28'h8181116, 28'h9181117, 28'h9080023};
  logic [27:0] t;
  int error_cnt = 0, n_tests = 0, cyc = 0;

  ids_sequencer dut (.clock, .rst_n, .instr_boundary, .pending_interrupt_reg_a, .pending_interrupt_reg_b,
    .int_xfer_index, .int_parameter, .current_instr, .stack_reg_count, .stack_reg_word0, .stack_reg_word1,
    .stack_reg_word2, .stack_reg_word3,
    .stack_ptr, .marker_word0, .marker_word1, .marker_word2, .marker_word3, .status_in, .marker_ptr,
    .interrupt_stack_base, .code_segment_table, .segment_transfer_table, .in_handler, .dispatch_instr,
    .dispatcher_lock_instr, .dispatcher_unlock_instr, .interrupt_exit_instr, .busy, .done, .halted, .index_reg,
    .status_reg, .code_bank, .code_base, .code_limit, .prog_counter, .ext_label, .fetch_start, .cond_code_greater,
    .enter_dispatcher, .exit_path, .reset_int_valid, .reset_int_device, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_ack, .mem_rdata);

  always #50 clock = ~clock;

  // Memory answers one cycle after a request; idle read data is scrambled
  always @(posedge clock) begin
    mem_ack <= mem_req && !mem_ack;
    ev <= ev | {fetch_start, enter_dispatcher, reset_int_valid};
    if (mem_req && !mem_ack) begin
      mem_rdata <= mem[mem_addr[7:0]];
      if (mem_we) begin
        mem[mem_addr[7:0]] <= mem_wdata;
        wlog.push_back({mem_addr, mem_wdata});
      end
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      $display("unexpected at %0t: run too long", $time);
      final_report();
    end
  end

  task automatic final_report;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // Pulses {boundary, dispatch, lock, unlock, exit} for one cycle and waits for completion
  task automatic op(input logic [4:0] k);
    int n;
    n = 0;
    #1;
    ev = 3'b000;
    wlog.delete();
    @(posedge clock);
    {instr_boundary, dispatch_instr, dispatcher_lock_instr, dispatcher_unlock_instr, interrupt_exit_instr} <= k;
    do begin
      @(posedge clock);
      if (n == 0)
        {instr_boundary, dispatch_instr, dispatcher_lock_instr, dispatcher_unlock_instr, interrupt_exit_instr} <= 5'h00;
      #1;
      n++;
    end while (done !== 1'b1 && halted !== 1'b1 && n < 300);
    chk(n < 300, 1'b1, "completion");
    repeat (2) @(posedge clock);
  endtask : op

  initial begin
    mem[8'h40] = 16'h0002;
    mem[8'h41] = 16'h0100;
    mem[8'h42] = 16'h01ff;
    mem[8'h63] = 16'h0020;
    mem[8'h80] = 16'h0080;
    mem[8'h6e] = 16'h0000;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk({status_reg, 13'h0000, halted, busy, done}, 32'h0, "reset state");
    pending_interrupt_reg_b <= 16'h0100;
    repeat (5) @(posedge clock);
    chk(busy, 1'b0, "idle off boundary");
    op(5'b10000);
    pending_interrupt_reg_b <= 16'h0000;
    chk(wlog.size(), 9, "entry write count");
    for (int i = 0; i < 9; i++) begin
      chk(wlog[i], {16'h0011 + 16'(i), (i < 4) ? 16'ha000 + 16'(i) : (i < 8) ? 16'hb000 + 16'(i - 4) : 16'h55aa},
        "entry push");
    end
    chk(index_reg, 16'h1234, "index");
    chk(ext_label, 16'h0301, "label");
    chk({code_bank, code_base}, 32'h00020100, "bank base");
    chk(code_limit, 16'h01ff, "limit");
    chk(status_reg, 16'h8001, "status");
    chk({prog_counter, 13'h0000, ev}, {16'h0120, 16'h0004}, "pc and fetch");
    op(5'b01000);
    chk({ev[1], mem[8'h80]}, {1'b0, 16'h0080}, "unprivileged dispatch");
    status_in <= 16'h8005;
    op(5'b01000);
    chk(ev[1], 1'b1, "dispatch");
    in_handler <= 1'b1;
    op(5'b01000);
    chk({cond_code_greater, ev[1], mem[8'h80]}, {2'b10, 16'h0081}, "handler dispatch");
    in_handler <= 1'b0;
    mem[8'h80] = 16'h0080;
    op(5'b00100);
    op(5'b00100);
    chk(mem[8'h6e], 16'h0002, "lock count");
    op(5'b01000);
    chk({ev[1], mem[8'h80]}, {1'b0, 16'h0081}, "locked dispatch");
    op(5'b00010);
    chk({mem[8'h6e], mem[8'h80]}, 32'h00010081, "first unlock");
    op(5'b00010);
    chk({mem[8'h6e], mem[8'h80]}, 32'h00000080, "last unlock");
    for (int i = 0; i < 8; i++) begin
      t = xt[i];
      marker_ptr <= {8'h00, t[27:20]};
      interrupt_stack_base <= {8'h00, t[19:12]};
      status_in <= {12'h800, t[7:4]};
      mem[t[19:12]] = {8'h00, t[19:12]};
      mem[t[19:12] - 8'h12] = {12'h000, t[11:8]};
      mem[t[27:20] + 8'h03] = 16'h0017;
      op(5'b00001);
      chk(exit_path, t[2:0], "exit path");
      chk(mem[t[19:12]], (t[3:0] == 4'h5) ? 16'h0000 : {8'h00, t[19:12]}, "base word");
      chk(ev[0], t[7:4] != 4'h1, "reset interrupt");
      if (t[7:4] != 4'h1)
        chk(reset_int_device, 16'h0017, "reset device");
    end
    interrupt_stack_base <= 16'h0080;
    mem[8'h6e] = 16'h0000;
    op(5'b00010);
    chk(halted, 1'b1, "halt");
    final_report();
  end
endmodule : tb
`default_nettype wire
